//--- ifa_aggregator.sv
// Purpose: Interrupt status and enable mask with open-drain request
// Assumes: Inputs synchronous to REF_CLK, events are one-cycle pulses
// Notes: Status read data is registered; clear follows the read
//
// Overview of operation
// - 16-bit read-only status register resets to 0x0080.
// - Bit 15 sets on special command completion, clears on read.
// - Bit 14 sets on aux converter sequence done, clears on read.
// - Bits 13/12 set on message end in burst mode, clear on read.
// - Bits 11 to 8 flag queue over/underflow, clear on read.
// - Bit 7 follows the transmit status trigger bit, not read-cleared.
// - Bits 6 to 4 follow fsk and receive trigger bits, not cleared.
// - Bit 3 sets on transmit done or error, clears on read.
// - Bits 2/1 set on packet ready in burst mode, clear on read.
// - Bit 0 sets on timing adjustment done, clears on read.
// - 16-bit write-only enable mask resets to zero.
// - Request line low when any status bit and its mask bit are set.
// - Mask writes never alter status contents.
// - Mask accepts writes at any time, any combination.
// - Request output is open-drain, active low, only pulls low.
`timescale 1ns/1ps
module ifa_aggregator
  import ifa_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic BURST_MODE,
  input wire logic SPCL_CMD_DONE,
  input wire logic AUX_CONV_DONE,
  input wire logic RX_B_MESSAGE_END,
  input wire logic RX_A_MESSAGE_END,
  input wire logic TX_QUEUE_FAULT,
  input wire logic FSK_QUEUE_FAULT,
  input wire logic RX_B_QUEUE_FAULT,
  input wire logic RX_A_QUEUE_FAULT,
  input wire logic TX_QUEUE_LOW_LEVEL,
  input wire logic FSK_QUEUE_HIGH_LEVEL,
  input wire logic RX_B_QUEUE_HIGH_LEVEL,
  input wire logic RX_A_QUEUE_HIGH_LEVEL,
  input wire logic TX_DONE,
  input wire logic TX_FAULT,
  input wire logic RX_B_PACKET_READY,
  input wire logic RX_A_PACKET_READY,
  input wire logic NUDGE_DONE,
  output logic HOST_IRQ_N_O,
  output logic HOST_IRQ_N_OE
);
  logic [15:0] event_raw;
  logic [15:0] event_set;
  logic [15:0] sticky;
  logic [15:0] status_now;
  logic [15:0] source_unmask_r;
  logic [15:0] rdata_r;
  logic [15:0] clr_r;
  logic [15:0] level_now;
  logic rd_status;
  logic wr_mask;
  logic irq_any;

  assign rd_status = REG_RD && (REG_ADDR == IFA_ADDR_STATUS);
  assign wr_mask = REG_WR && (REG_ADDR == IFA_ADDR_MASK);

  assign event_raw = {SPCL_CMD_DONE,
                      AUX_CONV_DONE,
                      RX_B_MESSAGE_END, RX_A_MESSAGE_END,
                      TX_QUEUE_FAULT, FSK_QUEUE_FAULT,
                      RX_B_QUEUE_FAULT, RX_A_QUEUE_FAULT,
                      4'h0,
                      TX_DONE | TX_FAULT,
                      RX_B_PACKET_READY, RX_A_PACKET_READY,
                      NUDGE_DONE};
  // Burst-only sources gated by mode
  assign event_set = event_raw &
    (~IFA_BURST_BITS | {IFA_W{BURST_MODE}});

  assign level_now = {8'h00, TX_QUEUE_LOW_LEVEL,
                      FSK_QUEUE_HIGH_LEVEL,
                      RX_B_QUEUE_HIGH_LEVEL, RX_A_QUEUE_HIGH_LEVEL,
                      4'h0};

  genvar g;
  generate
    for (g = 0; g < IFA_W; g = g + 1) begin : g_flag
      if (IFA_LEVEL_BITS[g]) begin : g_lvl
        assign sticky[g] = 1'b0;
      end else begin : g_stk
        ifa_flag_cell #(.RST_VAL(IFA_STATUS_RST[g])) u_cell (
          .clk(REF_CLK),
          .rst_n(RSTN),
          .set_i(event_set[g]),
          .clr_i(clr_r[g]),
          .flag_o(sticky[g])
        );
      end
    end
  endgenerate

  assign status_now = sticky | level_now;

  // Clear only what was returned, one cycle after the read
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      clr_r <= 16'h0000;
    end else begin
      clr_r <= rd_status ? (status_now & ~IFA_LEVEL_BITS) : 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= IFA_STATUS_RST;
    end else if (rd_status) begin
      rdata_r <= status_now;
    end
  end
  assign REG_RDATA = rdata_r;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      source_unmask_r <= IFA_MASK_RST;
    end else if (wr_mask) begin
      source_unmask_r <= REG_WDATA;
    end
  end

  assign irq_any = |(status_now & source_unmask_r);
  assign HOST_IRQ_N_O = 1'b0;
  assign HOST_IRQ_N_OE = irq_any;

  chk_irq_follows: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    HOST_IRQ_N_OE == |(status_now & source_unmask_r))
    else $error("irq enable mismatch");
  chk_irq_quiet: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    source_unmask_r == IFA_MASK_RST |-> !HOST_IRQ_N_OE)
    else $error("irq active with all sources masked");
  chk_irq_unmask: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    wr_mask && (REG_WDATA & sticky) != 16'h0000 && clr_r == 16'h0000
    |=> HOST_IRQ_N_OE)
    else $error("irq missing after unmask");
  chk_open_drain: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    HOST_IRQ_N_OE |-> !HOST_IRQ_N_O)
    else $error("request pin driven high");
  chk_mask_reset: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    $rose(RSTN) |-> source_unmask_r == IFA_MASK_RST)
    else $error("mask not zero");
  chk_mask_hold: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !wr_mask |=> $stable(source_unmask_r))
    else $error("mask changed without write");
  chk_mask_write: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    wr_mask |=> source_unmask_r == $past(REG_WDATA))
    else $error("mask write lost");
  chk_mask_nostat: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    wr_mask && !rd_status && clr_r == 16'h0000 && event_set == 16'h0000
    |=> (sticky == $past(sticky)))
    else $error("mask write changed status");
  chk_set_wins: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (event_set & clr_r) != 16'h0000
    |=> (sticky & $past(event_set & clr_r)) ==
        $past(event_set & clr_r))
    else $error("event lost on clear");
  chk_read_clear: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (rd_status && status_now[14]) ##1 !event_set[14] ##1 !event_set[14]
    |-> !sticky[14])
    else $error("flag not cleared");
  chk_unread_kept: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    rd_status && !status_now[0] && event_set[0] |-> ##2 sticky[0])
    else $error("unread flag cleared");
  chk_rdata_load: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    rd_status |=> REG_RDATA == $past(status_now))
    else $error("read data not status");
  chk_rdata_hold: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !rd_status |=> $stable(REG_RDATA))
    else $error("read data changed without read");
  chk_spcl_set: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    SPCL_CMD_DONE |=> sticky[15])
    else $error("command flag not set");
  chk_burst_gate: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (!BURST_MODE && !sticky[13] && !clr_r[13]) |=> !sticky[13])
    else $error("burst flag outside burst");
  chk_burst_msg: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    BURST_MODE && RX_A_MESSAGE_END |=> sticky[12])
    else $error("message flag not set");
  chk_fault_set: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    RX_B_QUEUE_FAULT |=> sticky[9])
    else $error("fault flag not set");
  chk_level_bit: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    status_now[IFA_TRIG_BIT] == TX_QUEUE_LOW_LEVEL)
    else $error("trigger bit mismatch");
  chk_level_rx: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    status_now[6:4] == {FSK_QUEUE_HIGH_LEVEL, RX_B_QUEUE_HIGH_LEVEL,
                        RX_A_QUEUE_HIGH_LEVEL})
    else $error("level bits mismatch");
  chk_level_kept: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    rd_status |=> (clr_r & IFA_LEVEL_BITS) == 16'h0000)
    else $error("level bit cleared by read");
  chk_tx_done: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (TX_DONE || TX_FAULT) |=> sticky[IFA_TX_BIT])
    else $error("tx flag not set");
  chk_packet_set: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    BURST_MODE && RX_B_PACKET_READY |=> sticky[2])
    else $error("packet flag not set");
  chk_nudge_set: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    NUDGE_DONE |=> sticky[0])
    else $error("timing flag not set");

  cov_irq: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    $rose(HOST_IRQ_N_OE));
  cov_read_clear: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    rd_status && status_now[15] ##2 !sticky[15]);
  cov_collide: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    event_set[0] && clr_r[0]);
  cov_burst_msg: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    BURST_MODE && event_set[13]);
  cov_unread: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    rd_status && !status_now[0] && event_set[0]);
endmodule // ifa_aggregator

//--- ifa_pkg.sv
// Purpose: Constants for the interrupt flag aggregator
// Assumes: Serial control port delivers decoded register accesses
// Notes: Addresses are the register indexes of the control port
package ifa_pkg;
  localparam int IFA_W = 16;
  localparam logic [7:0] IFA_ADDR_STATUS = 8'h80;
  localparam logic [7:0] IFA_ADDR_MASK = 8'h81;
  localparam logic [15:0] IFA_STATUS_RST = 16'h0080;
  localparam logic [15:0] IFA_MASK_RST = 16'h0000;
  // Level-driven flag positions, bits 7 to 4
  localparam logic [15:0] IFA_LEVEL_BITS = 16'h00f0;
  localparam int IFA_TRIG_BIT = 7;
  localparam int IFA_TX_BIT = 3;
  localparam int IFA_LVL_LO = 4;
  localparam int IFA_LVL_N = 4;
  // Positions of burst-mode-only flags: 13, 12, 2, 1
  localparam logic [15:0] IFA_BURST_BITS = 16'h3006;
endpackage : ifa_pkg

//--- ifa_flag_cell.sv
// Purpose: One sticky clear-on-read flag
// Assumes: Clear pulse lasts one cycle
// Notes: Set wins over clear
`timescale 1ns/1ps
module ifa_flag_cell
  import ifa_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_r;
  logic flag_nxt;
  assign flag_nxt = set_i | (flag_r & ~clr_i);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= RST_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag_o = flag_r;
endmodule // ifa_flag_cell

//--- ifa_host_model.sv
// Purpose: Host controller model on the register port
// Assumes: Device samples strobes on the rising clock
// Notes: Waits for the request line under a bounded count
`timescale 1ns/1ps
module ifa_host_model (
  input wire logic clk,
  input wire logic irq_n,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end
  // One access, result one cycle after the strobe edge
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #1;
    addr = a;
    wr = w;
    rd = !w;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
    @(posedge clk);
    #1;
    q = rdata;
  endtask
  // Bounded wait for the request line
  task automatic wait_irq(output logic seen);
    seen = 1'b0;
    repeat (8) begin
      if (irq_n === 1'b0) seen = 1'b1;
      @(posedge clk);
      #1;
    end
  endtask
endmodule // ifa_host_model

//--- test_interrupt_flag_aggregator.sv
// Purpose: Self-checking bench for the flag aggregator
// Assumes: Request pin has a pull-up on the board
// Notes: Random events, levels and masks from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module test_interrupt_flag_aggregator;
  import ifa_pkg::*;
  logic clk, rstn, burst, wr, rd, oe, o, seen;
  logic [7:0] addr;
  logic [15:0] wd, rdat, ev, st, q, msk, e;
  logic [3:0] lv;
  logic [31:0] seed;
  int miscompares, n_tests;
  wire irq_n = oe ? o : 1'b1;
  wire [15:0] full = st | {8'h00, lv, 4'h0};
  ifa_aggregator dut (.REF_CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdat),
    .BURST_MODE(burst), .SPCL_CMD_DONE(ev[15]), .AUX_CONV_DONE(ev[14]),
    .RX_B_MESSAGE_END(ev[13]), .RX_A_MESSAGE_END(ev[12]),
    .TX_QUEUE_FAULT(ev[11]), .FSK_QUEUE_FAULT(ev[10]),
    .RX_B_QUEUE_FAULT(ev[9]), .RX_A_QUEUE_FAULT(ev[8]),
    .TX_QUEUE_LOW_LEVEL(lv[3]), .FSK_QUEUE_HIGH_LEVEL(lv[2]),
    .RX_B_QUEUE_HIGH_LEVEL(lv[1]), .RX_A_QUEUE_HIGH_LEVEL(lv[0]),
    .TX_DONE(ev[3]), .TX_FAULT(ev[4]), .RX_B_PACKET_READY(ev[2]),
    .RX_A_PACKET_READY(ev[1]), .NUDGE_DONE(ev[0]), .HOST_IRQ_N_O(o),
    .HOST_IRQ_N_OE(oe));
  ifa_host_model u_host (.clk(clk), .irq_n(irq_n), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wd), .rdata(rdat));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Sticky flags after one event cycle
  function automatic logic [15:0] fold(input logic [15:0] s,
                                       input logic [15:0] v, input logic b);
    logic [15:0] m;
    m = v & ~IFA_LEVEL_BITS;
    m[IFA_TX_BIT] = v[3] | v[4];
    if (!b) m = m & ~IFA_BURST_BITS;
    return s | m;
  endfunction
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    #1;
    ev = v;
    @(posedge clk);
    #1;
    ev = 16'h0000;
    st = fold(st, v, burst);
  endtask
  task give_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 6000);
    miscompares++;
    give_verdict;
  end
  initial begin
    rstn = 1'b0;
    burst = 1'b0;
    ev = 16'h0000;
    lv = 4'h8;
    st = 16'h0000;
    seed = 32'd96395;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    `CHK(irq_n, 1'b1)
    u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
    `CHK(q, IFA_STATUS_RST)
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      burst = (i < 2) ? i[0] : seed[20];
      lv = seed[24:21];
      e = (i < 2) ? 16'hffff : seed[15:0];
      pulse(e);
      seed = lfsr(seed);
      msk = (i == 2) ? 16'h0000 : seed[31:16];
      u_host.acc(IFA_ADDR_MASK, 1'b1, msk, q);
      u_host.acc(8'h82, 1'b1, ~msk, q);
      u_host.wait_irq(seen);
      `CHK(seen, |(full & msk))
      u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
      `CHK(q, full)
      e = full;
      st = 16'h0000;
      u_host.acc(IFA_ADDR_MASK, 1'b0, 16'h0000, q);
      `CHK(q, e)
    end
    fork
      u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
      begin
        @(posedge clk);
        #1;
        ev = 16'h0001;
        @(posedge clk);
        #1;
        ev = 16'h0000;
      end
    join
    `CHK(q, full)
    st = 16'h0001;
    fork
      u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
      begin
        repeat (2) @(posedge clk);
        #1;
        ev = 16'h0001;
        @(posedge clk);
        #1;
        ev = 16'h0000;
      end
    join
    `CHK(q, full)
    u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
    `CHK(q, full)
    st = 16'h0000;
    u_host.acc(IFA_ADDR_STATUS, 1'b0, 16'h0000, q);
    `CHK(q, full)
    give_verdict;
  end
endmodule // test_interrupt_flag_aggregator
